// *** verilog/ccep_top.sv ***
// Cascaded 16-bit event counter and PWM generator with an AXI4-Lite register slave.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ccep_cfg.svh"
module ccep_top
	import ccep_pkg::*;
#(
	parameter int SUB_DIV = 610,
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address channel.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data channel.
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address channel.
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// External count input and system clock mode.
	input wire logic count_input_pin,
	input wire logic slow_mode,
	// Timer outputs.
	output logic pwm_out_n,
	output logic match_irq
);
	// The control byte is laid out as follows.
	// Bit 0 picks the mode: zero counts events, one generates the PWM wave.
	// Bit 1 makes the PWM counter take the external pin instead of a tap.
	// Bit 2 is spare; it is stored and read back but drives nothing.
	// Bit 3 is the run bit, which starts and stops the cascaded counter.
	// Bits 6 to 4 choose the internal source clock tap.
	// Bit 7 is the starting level that the toggle flop takes while stopped.
	// All fields live in one byte, so one write changes them together.
	// Software should therefore stop the counter in one write and move the
	// flop level in a second write, never both at once.
	// Upper counter control byte: mode, source, run, tap and flop bit.
	logic [7:0] upper_counter_control;
	// Period compare bytes, unbuffered.
	logic [7:0] period_compare_low;
	logic [7:0] period_compare_high;
	// Duty bytes as written by software.
	logic [7:0] duty_compare_low;
	logic [7:0] duty_compare_high;
	// Active duty value used for matching and read back.
	logic [15:0] duty_active;
	// Cascaded up-counter.
	logic [15:0] count;
	// Toggle flip-flop driving the inverted PWM pin.
	logic toggle_flop;
	// Sticky match status; set by hardware, cleared by writing one.
	logic match_seen;
	// Write channel holding registers and flags.
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	// Read channel state.
	logic [1:0] next_rresp;

	// Control field views.
	wire run_bit = upper_counter_control[`CCEP_BIT_RUN];
	wire flop_initial_bit = upper_counter_control[`CCEP_BIT_FLOP_INIT];
	wire pwm_mode = upper_counter_control[`CCEP_BIT_MODE] == CCEP_MODE_PWM;
	wire ext_src = upper_counter_control[`CCEP_BIT_EXT_SRC];
	wire [15:0] period_compare = {period_compare_high, period_compare_low};
	wire [15:0] duty_written = {duty_compare_high, duty_compare_low};

	// Tick sources.
	ccep_tick_if tk_bus ();
	logic ext_fall;
	assign tk_bus.tap = upper_counter_control[`CCEP_MSB_TAP:`CCEP_LSB_TAP];
	assign tk_bus.slow_mode = slow_mode;

	// Internal source clock selector.
	ccep_source_select #(
		.SUB_DIV(SUB_DIV)
	) u_sel (
		.aclk(aclk),
		.aresetn(aresetn),
		.tk(tk_bus)
	);

	// External input edge detector; the source keeps each level one cycle at least.
	ccep_event_edge u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_in(count_input_pin),
		.fall(ext_fall)
	);

	// Each count step is a single-cycle enable; the counter never runs on its own clock.
	// A pin event lands in the same cycle the pin is first seen low, because the edge
	// detector compares the present level with the one registered before it.
	// The external source must keep each level for one cycle at least, or a
	// short pulse between two samples is lost and the count falls behind.
	// In event mode the pin is the only source, whatever the tap field says.
	// In PWM mode bit 1 chooses between the pin and the selected tap.
	// The run bit gates every step, so a stopped counter keeps its value.
	// Count enable: event mode always uses the pin, PWM mode as configured.
	wire count_step = run_bit && (pwm_mode ? (ext_src ? ext_fall : tk_bus.tick) : ext_fall);
	// Event mode match against the live compare value.
	wire event_match = !pwm_mode && count_step && (count == period_compare);
	// PWM duty match and overflow.
	wire duty_match = pwm_mode && count_step && (count == duty_active) && (count != `CCEP_ALL_ONES);
	wire overflow = pwm_mode && count_step && (count == `CCEP_ALL_ONES);

	// A write lands once both address and data are held and no response is pending.
	// Only the lowest byte lane carries register data; the upper lanes are ignored.
	// An offset outside the map is answered with an error and changes nothing.
	// The count register is read only; a write to it is accepted and dropped.
	// The status match bit is cleared by writing a one to it.
	// Holding both halves in registers lets the master offer them in any order.
	// The response stays up until the master takes it, and a new write waits.
	// Bus write decode.
	wire wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire [7:0] wr_off = 8'(aw_addr);
	wire wr_ctrl = wr_fire && wr_off == `CCEP_OFF_CONTROL && w_strb[0];
	wire wr_plow = wr_fire && wr_off == `CCEP_OFF_PERIOD_LOW && w_strb[0];
	wire wr_phigh = wr_fire && wr_off == `CCEP_OFF_PERIOD_HIGH && w_strb[0];
	wire wr_dlow = wr_fire && wr_off == `CCEP_OFF_DUTY_LOW && w_strb[0];
	wire wr_dhigh = wr_fire && wr_off == `CCEP_OFF_DUTY_HIGH && w_strb[0];
	wire wr_stat = wr_fire && wr_off == `CCEP_OFF_STATUS && w_strb[0];
	wire wr_known = wr_off == `CCEP_OFF_CONTROL || wr_off == `CCEP_OFF_PERIOD_LOW
		|| wr_off == `CCEP_OFF_PERIOD_HIGH || wr_off == `CCEP_OFF_DUTY_LOW
		|| wr_off == `CCEP_OFF_DUTY_HIGH || wr_off == `CCEP_OFF_COUNT
		|| wr_off == `CCEP_OFF_STATUS;
	wire [7:0] ctrl_new = w_data[7:0];
	// Flop bit may only move while the counter stays stopped, not in the stopping write.
	wire flop_load = wr_ctrl && !run_bit && !ctrl_new[`CCEP_BIT_RUN];

	// Read decode; the duty address returns the active value.
	wire [7:0] rd_off = 8'(s_axi_araddr);
	wire rd_take = s_axi_arvalid && !s_axi_rvalid;
	logic [31:0] rd_word;
	always_comb begin
		next_rresp = `CCEP_RESP_OKAY;
		case (rd_off)
			`CCEP_OFF_CONTROL: rd_word = {24'h000000, upper_counter_control};
			`CCEP_OFF_PERIOD_LOW: rd_word = {24'h000000, period_compare_low};
			`CCEP_OFF_PERIOD_HIGH: rd_word = {24'h000000, period_compare_high};
			`CCEP_OFF_DUTY_LOW: rd_word = {24'h000000, duty_active[7:0]};
			`CCEP_OFF_DUTY_HIGH: rd_word = {24'h000000, duty_active[15:8]};
			`CCEP_OFF_COUNT: rd_word = {16'h0000, count};
			`CCEP_OFF_STATUS: rd_word = {30'h00000000, toggle_flop, match_seen};
			default: begin
				rd_word = `CCEP_ZERO32;
				next_rresp = `CCEP_RESP_SLVERR;
			end
		endcase
	end

	// Ready outputs are combinational: accept each channel while nothing is held.
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	// Inverted PWM pin follows the flop at all times.
	assign pwm_out_n = !toggle_flop;

	// Write address and data capture, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= `CCEP_ZERO32;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response, raised once both halves were used.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CCEP_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_known ? `CCEP_RESP_OKAY : `CCEP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read data register, loaded when the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `CCEP_ZERO32;
			s_axi_rresp <= `CCEP_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= next_rresp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Control and compare registers; period bytes act immediately.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			upper_counter_control <= `CCEP_RESET_BYTE;
			period_compare_low <= `CCEP_RESET_BYTE;
			period_compare_high <= `CCEP_RESET_BYTE;
			duty_compare_low <= `CCEP_RESET_BYTE;
			duty_compare_high <= `CCEP_RESET_BYTE;
		end else begin
			if (wr_ctrl) begin
				upper_counter_control <= ctrl_new;
			end
			if (wr_plow) begin
				period_compare_low <= w_data[7:0];
			end
			if (wr_phigh) begin
				period_compare_high <= w_data[7:0];
			end
			if (wr_dlow) begin
				duty_compare_low <= w_data[7:0];
			end
			if (wr_dhigh) begin
				duty_compare_high <= w_data[7:0];
			end
		end
	end

	// The duty value is double buffered so a running wave never sees half an update.
	// Software writes the two bytes into the written copy at any time.
	// While the counter runs, the written copy moves across only at overflow.
	// A write that lands on the overflow cycle itself may mix old and new bytes,
	// so software should write just after the overflow interrupt.
	// While stopped, the active copy follows the written one on every cycle.
	// Reads of the duty offsets always show the active copy.
	// While running, a fresh value therefore reads back only after the next overflow.
	// Active duty: copied at overflow while running, at once while stopped.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			duty_active <= `CCEP_RESET_WORD;
		end else if (!run_bit) begin
			duty_active <= duty_written;
		end else if (overflow) begin
			duty_active <= duty_written;
		end
	end

	// Cascaded counter: event match and overflow clear it, duty match does not.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= `CCEP_RESET_WORD;
		end else if (event_match || overflow) begin
			count <= `CCEP_RESET_WORD;
		end else if (count_step) begin
			count <= count + `CCEP_ONE;
		end
	end

	// The toggle flop is the only state behind the inverted PWM pin.
	// A duty match inverts it once in the period and overflow inverts it again.
	// A duty value of all ones never matches on its own; overflow handles it.
	// The starting level comes from bit 7, but only while stopped before and after
	// the write, so a stopping write cannot also move the pin level.
	// When the counter stops, the flop simply keeps its level, and so does the pin.
	// Reset clears the flop, which leaves the inverted pin high.
	// Choosing the starting level gives positive or negative pulses.
	// Toggle flop: reset to zero, loads the initial bit while stopped, inverts on events.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			toggle_flop <= 1'b0;
		end else if (flop_load) begin
			toggle_flop <= ctrl_new[`CCEP_BIT_FLOP_INIT];
		end else if (duty_match || overflow) begin
			toggle_flop <= !toggle_flop;
		end
	end

	// The interrupt is a registered one-cycle pulse, one clock after the step.
	// In event mode it marks the compare match; in PWM mode it marks overflow.
	// The sticky status bit lets software poll for a match it did not catch.
	// If a new match and a clear land together, the match is kept so no event
	// is lost; software sees the bit still set and clears it again.
	// The block has no interrupt controller; the pulse goes to the outside.
	// Match pulse and sticky status; a new match wins over the clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_irq <= 1'b0;
			match_seen <= 1'b0;
		end else begin
			match_irq <= event_match || overflow;
			if (event_match || overflow) begin
				match_seen <= 1'b1;
			end else if (wr_stat && w_data[`CCEP_BIT_STATUS_MATCH]) begin
				match_seen <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/ccep_cfg.svh ***
// Register offsets, field positions, reset values and response codes for the cascaded counter.
`ifndef CCEP_CFG_SVH
`define CCEP_CFG_SVH
`define CCEP_OFF_CONTROL 8'h00
`define CCEP_OFF_PERIOD_LOW 8'h04
`define CCEP_OFF_PERIOD_HIGH 8'h08
`define CCEP_OFF_DUTY_LOW 8'h0C
`define CCEP_OFF_DUTY_HIGH 8'h10
`define CCEP_OFF_COUNT 8'h14
`define CCEP_OFF_STATUS 8'h18
`define CCEP_BIT_MODE 0
`define CCEP_BIT_EXT_SRC 1
`define CCEP_BIT_RUN 3
`define CCEP_LSB_TAP 4
`define CCEP_MSB_TAP 6
`define CCEP_BIT_FLOP_INIT 7
`define CCEP_BIT_STATUS_MATCH 0
`define CCEP_BIT_STATUS_FLOP 1
`define CCEP_RESET_BYTE 8'h00
`define CCEP_RESET_WORD 16'h0000
`define CCEP_ALL_ONES 16'hFFFF
`define CCEP_ONE 16'h0001
`define CCEP_RESP_OKAY 2'h0
`define CCEP_RESP_SLVERR 2'h2
`define CCEP_ZERO32 32'h0000_0000
`endif

// *** verilog/ccep_pkg.sv ***
// Types shared by the cascaded counter design files.
package ccep_pkg;
	typedef enum logic [0:0] {
		CCEP_MODE_EVENT = 1'b0,
		CCEP_MODE_PWM = 1'b1
	} ccep_mode_t;
	typedef enum logic [2:0] {
		CCEP_TAP_DIV2048 = 3'b000,
		CCEP_TAP_DIV128 = 3'b001,
		CCEP_TAP_DIV32 = 3'b010,
		CCEP_TAP_DIV8 = 3'b011,
		CCEP_TAP_SUB = 3'b100,
		CCEP_TAP_DIV2 = 3'b101,
		CCEP_TAP_DIV1 = 3'b110,
		CCEP_TAP_SUB8 = 3'b111
	} ccep_tap_t;
endpackage

// *** verilog/ccep_tick_if.sv ***
// Tick bundle between the source clock selector and the counter core.
`timescale 1ns/1ps
`default_nettype none
interface ccep_tick_if;
	// Selected tap code from the control register.
	logic [2:0] tap;
	// Slow clock mode flag; main clock taps are silenced while it is high.
	logic slow_mode;
	// One-cycle tick of the selected internal source clock.
	logic tick;
	modport sel (input tap, input slow_mode, output tick);
	modport core (output tap, output slow_mode, input tick);
endinterface
`default_nettype wire

// *** verilog/ccep_source_select.sv ***
// Prescaler and source clock selector producing one-cycle tick enables.
`timescale 1ns/1ps
`default_nettype none
module ccep_source_select
	import ccep_pkg::*;
#(
	parameter int SUB_DIV = 610
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Tick bundle.
	ccep_tick_if.sel tk
);
	// Free running main prescaler; bit k toggles at aclk/2^(k+1).
	logic [10:0] pre;
	// Previous prescaler value for rising edge detection of each tap.
	logic [10:0] pre_d;
	// Subclock divider counter and its one-cycle pulse.
	logic [15:0] sub_cnt;
	logic sub_tick;
	// Subclock divided by eight.
	logic [2:0] sub8;
	// Edge pulses of each prescaler bit.
	wire [10:0] edge_pulse = pre & ~pre_d;
	wire sub_end = (sub_cnt == 16'(SUB_DIV - 1));
	wire sub8_tick = sub_tick && (sub8 == 3'h7);
	// Main clock taps are blocked in slow mode.
	wire main_ok = !tk.slow_mode;

	// Prescaler chain advancing every cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre <= 11'h000;
			pre_d <= 11'h000;
			sub_cnt <= `CCEP_RESET_WORD;
			sub_tick <= 1'b0;
			sub8 <= 3'h0;
		end else begin
			pre <= pre + 11'h001;
			pre_d <= pre;
			sub_cnt <= sub_end ? `CCEP_RESET_WORD : sub_cnt + `CCEP_ONE;
			sub_tick <= sub_end;
			if (sub_tick) begin
				sub8 <= sub8 + 3'h1;
			end
		end
	end

	// Tap selection; main clock taps only count outside slow mode.
	always_comb begin
		case (ccep_tap_t'(tk.tap))
			CCEP_TAP_DIV2048: tk.tick = main_ok && edge_pulse[10];
			CCEP_TAP_DIV128: tk.tick = main_ok && edge_pulse[6];
			CCEP_TAP_DIV32: tk.tick = main_ok && edge_pulse[4];
			CCEP_TAP_DIV8: tk.tick = main_ok && edge_pulse[2];
			CCEP_TAP_SUB: tk.tick = sub_tick;
			CCEP_TAP_DIV2: tk.tick = main_ok && edge_pulse[0];
			CCEP_TAP_DIV1: tk.tick = main_ok;
			CCEP_TAP_SUB8: tk.tick = sub8_tick;
			default: tk.tick = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// *** verilog/ccep_event_edge.sv ***
// Falling edge detector for the external count input.
`timescale 1ns/1ps
`default_nettype none
module ccep_event_edge (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// External level, taken as synchronous.
	input wire logic level_in,
	// One-cycle pulse on each falling edge.
	output logic fall
);
	// Previous sampled level; idles high so reset gives no false edge.
	logic prev;

	// Register the level for edge comparison.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev <= 1'b1;
		end else begin
			prev <= level_in;
		end
	end

	// A high to low step is one event.
	assign fall = prev && !level_in;
endmodule
`default_nettype wire

// *** dv/ccep_pulse_model.sv ***
// External pulse source that drives falling edges onto the count input.
`timescale 1ns/1ps
`default_nettype none
module ccep_pulse_model #(
	parameter int HALF = 4
) (
	// Clock and bench request.
	input wire logic aclk,
	input wire logic go,
	input wire logic [7:0] n_falls,
	// Pin side.
	output logic count_input_pin,
	output logic busy
);
	// The pin idles high like a pulled-up line; each level is held HALF cycles.
	initial begin
		count_input_pin = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge aclk);
			if (go) begin
				busy <= 1'b1;
				repeat (n_falls) begin
					repeat (HALF) @(posedge aclk);
					count_input_pin <= 1'b0;
					repeat (HALF) @(posedge aclk);
					count_input_pin <= 1'b1;
				end
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/ccep_top_monitor.sv ***
// Concurrent checks on the cascaded counter top-level ports.
`timescale 1ns/1ps
`default_nettype none
`include "ccep_cfg.svh"
module ccep_top_monitor #(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register write path.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	// Timer pins.
	input wire logic count_input_pin,
	input wire logic pwm_out_n,
	input wire logic match_irq
);
	// Shadow of the last write and of the run and mode bits.
	logic [ADDR_W-1:0] wa;
	logic [7:0] wd;
	logic run_sh, mode_sh, bv_q, pin_q;
	logic [3:0] sf;
	wire ctl_done = s_axi_bvalid && !bv_q && wa == ADDR_W'(`CCEP_OFF_CONTROL);
	// Address and data are latched as each channel is taken.
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
	end
	// The shadow lags the register by one cycle, which the checks allow for.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_sh <= 1'b0;
			mode_sh <= 1'b0;
		end else if (ctl_done) begin
			run_sh <= wd[`CCEP_BIT_RUN];
			mode_sh <= wd[`CCEP_BIT_MODE];
		end
	end
	// Cycles since the count input last fell, saturating.
	always_ff @(posedge aclk) begin
		bv_q <= aresetn && s_axi_bvalid;
		pin_q <= count_input_pin;
		if (!aresetn) sf <= 4'hF;
		else if (pin_q && !count_input_pin) sf <= 4'h0;
		else if (sf != 4'hF) sf <= sf + 4'h1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_state: assert property ($rose(aresetn) |-> pwm_out_n && !match_irq)
		else $error("Pin or interrupt wrong after reset.");
	a_irq_single: assert property (match_irq |=> !match_irq)
		else $error("Match interrupt longer than one cycle.");
	a_stop_pin_hold: assert property (!run_sh && !$past(run_sh) && !$rose(s_axi_bvalid)
		|-> $stable(pwm_out_n))
		else $error("Pin moved while stopped.");
	a_stop_no_irq: assert property (!run_sh && !$past(run_sh) |-> !match_irq)
		else $error("Interrupt while stopped.");
	a_event_irq_cause: assert property (match_irq && !mode_sh |-> sf < 4'h5)
		else $error("Event interrupt without a falling edge.");
	a_pwm_irq_flop: assert property (match_irq && mode_sh |-> $past(pwm_out_n) !=
		$past(pwm_out_n, 2) || pwm_out_n != $past(pwm_out_n))
		else $error("Overflow interrupt without flop inversion.");
	a_flop_load: assert property (ctl_done && !wd[`CCEP_BIT_RUN] && !run_sh
		|-> pwm_out_n == !wd[`CCEP_BIT_FLOP_INIT])
		else $error("Pin does not follow flop initial bit.");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("Write response late.");
	cover property (match_irq && !mode_sh);
	cover property (match_irq && mode_sh);
	cover property (ctl_done && !run_sh);
endmodule
bind ccep_top ccep_top_monitor #(.ADDR_W(ADDR_W)) ccep_top_monitor_inst (.*);
`default_nettype wire

// *** dv/ccep_top_test.sv ***
// Self-checking bench for the cascaded counter top level.
`timescale 1ns/1ps
`default_nettype none
`include "ccep_cfg.svh"
module ccep_top_test
	import ccep_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, n_falls = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, go = 1'b0, slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pin, pwm_out_n, match_irq, busy;
	logic [1:0] bresp, rresp;
	int n_errors = 0, checks = 0, n_irq = 0;
	// 20 MHz clock; interrupt pulses are counted as they come.
	always #25 aclk = ~aclk;
	always @(posedge aclk) if (match_irq === 1'b1) n_irq++;
	ccep_top #(.SUB_DIV(4)) ccep_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.count_input_pin(pin), .slow_mode(slow), .pwm_out_n(pwm_out_n), .match_irq(match_irq));
	ccep_pulse_model ccep_pulse_model_inst (.aclk(aclk), .go(go), .n_falls(n_falls),
		.count_input_pin(pin), .busy(busy));
	// Compares and reports one value.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Write with address and data offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
	endtask
	// Read one register; data and response are taken at the answer edge.
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(what, exp, d);
	endtask
	// A 16-bit value goes as low byte, then high byte.
	task automatic w16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
		wr(lo, {24'h0, v[7:0]});
		wr(hi, {24'h0, v[15:8]});
	endtask
	function automatic logic [31:0] ctl(input logic flop, run, ext, mode);
		return {24'h0, flop, CCEP_TAP_DIV1, run, 1'b0, ext, mode};
	endfunction
	// Asks the pulse source for n falling edges and waits until they have landed.
	task automatic falls(input logic [7:0] n);
		n_falls <= n;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		while (busy === 1'b1) @(posedge aclk);
		repeat (4) @(posedge aclk);
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		for (int a = 0; a <= 24; a += 4) rdc("reset value", 8'(a), 32'h0);
		rd(8'h1C, d, r);
		chk("unmapped response", 32'(`CCEP_RESP_SLVERR), 32'(r));
		wr(8'h1C, 32'h0);
		chk("unmapped write response", 32'(`CCEP_RESP_SLVERR), 32'(bresp));
		wr(`CCEP_OFF_COUNT, 32'h0);
		chk("count write response", 32'(`CCEP_RESP_OKAY), 32'(bresp));
		// The pin is dedicated to the timer here, so no shared port latch needs setting.
		chk("pin after reset", 32'h1, 32'(pwm_out_n));
		$display("Test reset done");
	endtask
	task automatic t_event;
		int k;
		w16(`CCEP_OFF_PERIOD_LOW, `CCEP_OFF_PERIOD_HIGH, 16'h0003);
		wr(`CCEP_OFF_CONTROL, ctl(0, 1, 0, 0));
		k = n_irq;
		falls(3);
		rdc("event count", `CCEP_OFF_COUNT, 32'h3);
		chk("irq before match", 32'(k), 32'(n_irq));
		falls(1);
		chk("irq at match", 32'(k + 1), 32'(n_irq));
		rdc("count after match", `CCEP_OFF_COUNT, 32'h0);
		falls(2);
		rdc("count after resume", `CCEP_OFF_COUNT, 32'h2);
		wr(`CCEP_OFF_CONTROL, ctl(0, 0, 0, 0));
		falls(1);
		rdc("count while stopped", `CCEP_OFF_COUNT, 32'h2);
		wr(`CCEP_OFF_PERIOD_LOW, 32'h1);
		rdc("period at once", `CCEP_OFF_PERIOD_LOW, 32'h1);
		$display("Test event done");
	endtask
	task automatic t_pwm;
		logic [31:0] d;
		logic [1:0] r;
		int t;
		logic p;
		wr(`CCEP_OFF_CONTROL, ctl(0, 0, 0, 1));
		w16(`CCEP_OFF_DUTY_LOW, `CCEP_OFF_DUTY_HIGH, 16'h0010);
		rdc("duty when stopped", `CCEP_OFF_DUTY_LOW, 32'h10);
		wr(`CCEP_OFF_CONTROL, ctl(0, 1, 0, 1));
		for (t = 0; t < 100 && pwm_out_n !== 1'b0; t++) @(posedge aclk);
		chk("pin at duty match", 32'h0, 32'(pwm_out_n));
		rd(`CCEP_OFF_COUNT, d, r);
		chk("count runs past duty", 32'h1, 32'(d > 32'h10));
		w16(`CCEP_OFF_DUTY_LOW, `CCEP_OFF_DUTY_HIGH, 16'h0020);
		rdc("duty while running", `CCEP_OFF_DUTY_LOW, 32'h10);
		t = n_irq;
		for (int c = 0; c < 70000 && n_irq == t; c++) @(posedge aclk);
		chk("pin at overflow", 32'h1, 32'(pwm_out_n));
		rd(`CCEP_OFF_COUNT, d, r);
		chk("count cleared", 32'h1, 32'(d < 32'h10));
		rdc("duty after overflow", `CCEP_OFF_DUTY_LOW, 32'h20);
		wr(`CCEP_OFF_CONTROL, ctl(0, 0, 0, 1));
		p = pwm_out_n;
		repeat (50) @(posedge aclk);
		chk("pin held when stopped", 32'(p), 32'(pwm_out_n));
		wr(`CCEP_OFF_CONTROL, ctl(1, 0, 0, 1));
		chk("pin for flop one", 32'h0, 32'(pwm_out_n));
		wr(`CCEP_OFF_CONTROL, ctl(0, 0, 0, 1));
		chk("pin for flop zero", 32'h1, 32'(pwm_out_n));
		rd(`CCEP_OFF_COUNT, d, r);
		slow <= 1'b1;
		wr(`CCEP_OFF_CONTROL, ctl(0, 1, 0, 1));
		repeat (20) @(posedge aclk);
		rdc("count held in slow mode", `CCEP_OFF_COUNT, d);
		wr(`CCEP_OFF_CONTROL, ctl(0, 0, 0, 1));
		slow <= 1'b0;
		$display("Test pwm done");
	endtask
	// External source in PWM mode after a reset in mid-run.
	task automatic t_ext;
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		w16(`CCEP_OFF_DUTY_LOW, `CCEP_OFF_DUTY_HIGH, 16'h0002);
		wr(`CCEP_OFF_CONTROL, ctl(0, 0, 1, 1));
		wr(`CCEP_OFF_CONTROL, ctl(0, 1, 1, 1));
		falls(2);
		rdc("external count", `CCEP_OFF_COUNT, 32'h2);
		chk("pin before match", 32'h1, 32'(pwm_out_n));
		falls(1);
		chk("pin after match", 32'h0, 32'(pwm_out_n));
		$display("Test external done");
	endtask
	task automatic wrap_up;
		$display("Checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#5000000;
		n_errors++;
		$display("Error watchdog expected finish seen hang");
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_event;
		t_pwm;
		t_ext;
		wrap_up;
	end
endmodule
`default_nettype wire
